// ### pkg/rrxif_consts.svh
`ifndef RRXIF_CONSTS_SVH
`define RRXIF_CONSTS_SVH
// Overview of operation
// - RR fetch: one cycle, four position words
// - Holding register has first, branch second
// - Nonbranch: holding through adder, read R2
// - Branch: swap operands, request at branch
// - Dispatch select from opcode bits 2-7
// - Exception overrides dispatch in every word
// - RR: counter plus one, refill queued halfword
// - Branch reset: instruction request, read R1
// - RR reset: clear flags, step 100, aux 000
// - Floating ops force top store address bit
// - Step rate sets stop trigger
// - Execute subject: no advance, refill, BC request
// - RX: sixteen words, one or two cycles
// - RX: counter plus two, refill unless 10
// - Base zero: displacement only, else sum
// - Conditional 3-cycle operand request, suppressions
// - RX: first operand read into mirror, holding
// - Indexed: base plus disp, then add index
// - RX reset: clear flags, both counters 000
// - RX reset starts branch and subject requests
// - Execute subject inhibits RX side effects
// - Pointer bit 8 index zero, bit 9 base zero

// ==========================================================
// Control word pointer and counters
`define RRXIF_CWP_BASE   6'h08
`define RRXIF_STC_RR     3'h4
`define RRXIF_STC_RX     3'h0
`define RRXIF_ABC_RST    3'h0
`define RRXIF_IC_RR      2'h1
`define RRXIF_IC_RX      2'h2
`define RRXIF_POS_NOQ    2'h2
// ==========================================================
// Formats and opcode bits 2-7
`define RRXIF_FMT_RR     2'h0
`define RRXIF_FMT_RX     2'h1
`define RRXIF_OP_STH     6'h00
`define RRXIF_OP_LA      6'h01
`define RRXIF_OP_STC     6'h02
`define RRXIF_OP_BC      6'h07
`define RRXIF_OP_RRBR_LO 6'h05
`define RRXIF_OP_RRBR_HI 6'h07
// ==========================================================
// Register map (byte offsets) and fields
`define RRXIF_OFF_CTRL   4'h0
`define RRXIF_OFF_STATUS 4'h4
`define RRXIF_OFF_FPTR   4'h8
`define RRXIF_CTRL_STEP  0
`define RRXIF_CTRL_STOPC 1
`endif

// ### pkg/rrxif_pkg.sv
package rrxif_pkg;
    typedef enum logic [3:0] {
        RRXIF_IDLE = 4'h1,
        RRXIF_RR   = 4'h2,
        RRXIF_RX1  = 4'h4,
        RRXIF_RX2  = 4'h8
    } rrxif_state_e;

    typedef struct packed {
        rrxif_state_e st;
        logic [15:0]  op;
        logic [15:0]  hw2;
        logic         x0;
        logic         b0;
        logic [31:0]  a;
        logic [31:0]  b;
        logic [31:0]  d;
        logic [31:0]  s;
        logic [31:0]  t;
        logic [15:0]  r;
        logic [1:0]   ic;
        logic [2:0]   step_count;
        logic [2:0]   abc;
        logic         stop;
        logic         step_rate;
        logic         sticky_clr;
        logic         oreq;
        logic         ireq;
        logic [31:0]  iaddr;
        logic [5:0]   sel;
        logic         go;
        logic         exc;
        logic [11:0]  cwp;
        logic         ph_v;
        logic         ph_w;
        logic [3:0]   ph_a;
        logic [31:0]  hrdata;
    } rrxif_state_s;
endpackage

// ### hdl/rrxif_fetch.sv
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "rrxif_consts.svh"

module rrxif_fetch (
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    // Sequencer side
    input  wire logic        start_i,
    input  wire logic [15:0] op_hw_i,
    input  wire logic [15:0] second_hw_i,
    input  wire logic [31:0] hold_i,
    input  wire logic [15:0] next_hw_i,
    input  wire logic        exec_i,
    input  wire logic        exception_i,
    input  wire logic        refill_exc_i,
    input  wire logic        bc_fail_i,
    input  wire logic        refill_need_i,
    input  wire logic [31:0] instr_counter_i,
    output logic             busy_o,
    output logic [11:0]      control_word_pointer_o,
    output logic [5:0]       exec_branch_select_o,
    output logic             exec_go_o,
    output logic             exception_override_o,
    output logic             sticky_clr_o,
    output logic [1:0]       instr_counter_o,
    output logic [2:0]       step_count_o,
    output logic [2:0]       aux_count_o,
    output logic             stop_o,
    output logic [15:0]      queued_hw_o,
    output logic [31:0]      work_a_o,
    output logic [31:0]      work_b_o,
    output logic [31:0]      fetch_ptr_o,
    output logic [31:0]      mirror_o,
    output logic [31:0]      hold_o,
    // Local store
    output logic [4:0]       local_addr_latch_o,
    input  wire logic [31:0] local_store_i,
    // Storage control interface
    output logic             oper_req_o,
    output logic [31:0]      oper_addr_o,
    output logic             instr_req_o,
    output logic [31:0]      instr_addr_o,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o
);
    rrxif_pkg::rrxif_state_s cur_r;
    rrxif_pkg::rrxif_state_s cur_nxt;

    function automatic logic [31:0] add32(input logic [31:0] x, input logic [31:0] y);
        add32 = x + y;
    endfunction

    function automatic logic is_rr_branch(input logic [5:0] opc);
        is_rr_branch = (opc >= `RRXIF_OP_RRBR_LO) && (opc <= `RRXIF_OP_RRBR_HI);
    endfunction

    logic [4:0]  ls_addr;
    logic [5:0]  opc;
    logic [1:0]  fmt;
    logic        flt;
    logic        fin;
    logic        rr_br;
    logic        no_oreq;
    logic [31:0] base;
    logic [31:0] ea;
    logic [31:0] iptr;

    // ==========================================================
    // Next state
    always_comb begin
        cur_nxt    = cur_r;
        ls_addr    = 5'h00;
        fin        = 1'b0;
        rr_br      = 1'b0;
        no_oreq    = 1'b0;
        opc        = cur_r.op[13:8];
        fmt        = cur_r.op[15:14];
        flt        = cur_r.op[13];
        base       = cur_r.b0 ? 32'h0000_0000 : cur_r.t;
        ea         = add32(base, {20'h00000, cur_r.hw2[11:0]});
        iptr       = exec_i ? cur_r.d : instr_counter_i;
        cur_nxt.sticky_clr = 1'b0;
        cur_nxt.oreq       = 1'b0;
        cur_nxt.ireq       = 1'b0;
        cur_nxt.go         = 1'b0;
        cur_nxt.exc        = 1'b0;

        // Zero-wait slave: read data is latched in the address phase
        cur_nxt.ph_v = hsel_i && htrans_i[1] && hready_i;
        cur_nxt.ph_w = hwrite_i;
        cur_nxt.ph_a = haddr_i[3:0];
        if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
            case (haddr_i[3:0])
                `RRXIF_OFF_CTRL:   cur_nxt.hrdata = {31'h0000_0000, cur_r.step_rate};
                `RRXIF_OFF_STATUS: cur_nxt.hrdata = {18'h00000, cur_r.st, 1'b0,
                                                     cur_r.stop, cur_r.abc,
                                                     cur_r.step_count, cur_r.ic};
                `RRXIF_OFF_FPTR:   cur_nxt.hrdata = cur_r.d;
                default:           cur_nxt.hrdata = 32'h0000_0000;
            endcase
        end
        if (cur_r.ph_v && cur_r.ph_w && (cur_r.ph_a == `RRXIF_OFF_CTRL)) begin
            cur_nxt.step_rate = hwdata_i[`RRXIF_CTRL_STEP];
            if (hwdata_i[`RRXIF_CTRL_STOPC]) begin
                cur_nxt.stop = 1'b0;
            end
        end

        // One control word per cycle; all loads land at the clock edge
        case (cur_r.st)
            rrxif_pkg::RRXIF_IDLE: begin
                if (start_i && (op_hw_i[15:14] == `RRXIF_FMT_RR ||
                                op_hw_i[15:14] == `RRXIF_FMT_RX)) begin
                    cur_nxt.op  = op_hw_i;
                    cur_nxt.hw2 = second_hw_i;
                    cur_nxt.t   = hold_i;
                    cur_nxt.x0  = (op_hw_i[15:14] == `RRXIF_FMT_RX) &&
                                  (op_hw_i[3:0] == 4'h0);
                    cur_nxt.b0  = (op_hw_i[15:14] != `RRXIF_FMT_RR) &&
                                  (second_hw_i[15:12] == 4'h0);
                    cur_nxt.cwp = {`RRXIF_CWP_BASE, op_hw_i[15:14],
                                   cur_nxt.x0, cur_nxt.b0, cur_r.ic};
                    cur_nxt.st  = (op_hw_i[15:14] == `RRXIF_FMT_RR) ?
                                  rrxif_pkg::RRXIF_RR : rrxif_pkg::RRXIF_RX1;
                end
            end
            rrxif_pkg::RRXIF_RR: begin
                rr_br     = is_rr_branch(opc);
                cur_nxt.a = add32(cur_r.t, 32'h0000_0000);
                cur_nxt.b = add32(cur_r.t, 32'h0000_0000);
                cur_nxt.d = add32(cur_r.t, 32'h0000_0000);
                // Branch reads R1 instead of R2
                ls_addr   = {flt, rr_br ? cur_r.op[7:4] : cur_r.op[3:0]};
                cur_nxt.s = local_store_i;
                cur_nxt.t = local_store_i;
                cur_nxt.sticky_clr = 1'b1;
                cur_nxt.step_count        = `RRXIF_STC_RR;
                cur_nxt.abc        = `RRXIF_ABC_RST;
                if (!exec_i) begin
                    cur_nxt.ic = cur_r.ic + `RRXIF_IC_RR;
                    cur_nxt.r  = next_hw_i;
                end
                if (rr_br && !bc_fail_i) begin
                    cur_nxt.ireq  = 1'b1;
                    cur_nxt.iaddr = cur_r.t;
                end else if (rr_br && !exec_i && refill_need_i) begin
                    cur_nxt.ireq  = 1'b1;
                    cur_nxt.iaddr = iptr;
                end
                fin = 1'b1;
            end
            rrxif_pkg::RRXIF_RX1: begin
                cur_nxt.sticky_clr = 1'b1;
                cur_nxt.step_count        = `RRXIF_STC_RX;
                cur_nxt.abc        = `RRXIF_ABC_RST;
                if (!exec_i) begin
                    cur_nxt.ic = cur_r.ic + `RRXIF_IC_RX;
                    if (cur_r.ic != `RRXIF_POS_NOQ) begin
                        cur_nxt.r = next_hw_i;
                    end
                end
                if (cur_r.x0) begin
                    cur_nxt.d = ea;
                    ls_addr   = {flt, cur_r.op[7:4]};
                    cur_nxt.s = local_store_i;
                    cur_nxt.t = local_store_i;
                    fin       = 1'b1;
                end else begin
                    cur_nxt.b  = ea;
                    ls_addr    = {1'b0, cur_r.op[3:0]};
                    cur_nxt.t  = local_store_i;
                    cur_nxt.st = rrxif_pkg::RRXIF_RX2;
                end
            end
            rrxif_pkg::RRXIF_RX2: begin
                cur_nxt.d = add32(cur_r.t, cur_r.b);
                ls_addr   = {flt, cur_r.op[7:4]};
                cur_nxt.s = local_store_i;
                cur_nxt.t = local_store_i;
                fin       = 1'b1;
            end
            default: begin
                cur_nxt.st = rrxif_pkg::RRXIF_IDLE;
            end
        endcase

        if (fin && fmt == `RRXIF_FMT_RX) begin
            // Stores and load address need no operand from storage
            no_oreq = refill_exc_i || (opc == `RRXIF_OP_STH) ||
                      (opc == `RRXIF_OP_STC) || (opc == `RRXIF_OP_LA) ||
                      (opc == `RRXIF_OP_BC);
            cur_nxt.oreq = !no_oreq;
            if (opc == `RRXIF_OP_BC && !bc_fail_i) begin
                cur_nxt.ireq  = 1'b1;
                cur_nxt.iaddr = cur_nxt.d;
            end else if (opc == `RRXIF_OP_BC && !exec_i && refill_need_i) begin
                cur_nxt.ireq  = 1'b1;
                cur_nxt.iaddr = iptr;
            end
        end

        if (fin) begin
            cur_nxt.sel = opc;
            cur_nxt.exc = exception_i;
            cur_nxt.go  = !exception_i;
            cur_nxt.st  = rrxif_pkg::RRXIF_IDLE;
            if (cur_r.step_rate) begin
                cur_nxt.stop = 1'b1;
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_r    <= '0;
            cur_r.st <= rrxif_pkg::RRXIF_IDLE;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign busy_o                 = cur_r.st != rrxif_pkg::RRXIF_IDLE;
    assign control_word_pointer_o = cur_r.cwp;
    assign exec_branch_select_o   = cur_r.sel;
    assign exec_go_o              = cur_r.go;
    assign exception_override_o   = cur_r.exc;
    assign sticky_clr_o           = cur_r.sticky_clr;
    assign instr_counter_o        = cur_r.ic;
    assign step_count_o           = cur_r.step_count;
    assign aux_count_o            = cur_r.abc;
    assign stop_o                 = cur_r.stop;
    assign queued_hw_o            = cur_r.r;
    assign work_a_o               = cur_r.a;
    assign work_b_o               = cur_r.b;
    assign fetch_ptr_o            = cur_r.d;
    assign mirror_o               = cur_r.s;
    assign hold_o                 = cur_r.t;
    assign local_addr_latch_o     = ls_addr;
    assign oper_req_o             = cur_r.oreq;
    assign oper_addr_o            = cur_r.d;
    assign instr_req_o            = cur_r.ireq;
    assign instr_addr_o           = cur_r.iaddr;
    assign hreadyout_o            = 1'b1;
    assign hresp_o                = 1'b0;
    assign hrdata_o               = cur_r.hrdata;

endmodule // rrxif_fetch

// ### testbench/rrxif_fetch_sva.sv
`timescale 1ns/1ps
module rrxif_fetch_sva (
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    input wire logic        start_i,
    input wire logic [15:0] op_hw_i,
    input wire logic        exec_i,
    input wire logic        exception_i,
    input wire logic        busy_o,
    input wire logic [5:0]  exec_branch_select_o,
    input wire logic        exec_go_o,
    input wire logic        exception_override_o,
    input wire logic        sticky_clr_o,
    input wire logic [1:0]  instr_counter_o,
    input wire logic [2:0]  step_count_o,
    input wire logic [2:0]  aux_count_o,
    input wire logic [4:0]  local_addr_latch_o,
    input wire logic        oper_req_o,
    input wire logic [31:0] oper_addr_o,
    input wire logic [31:0] fetch_ptr_o
);
    // ==========================================================
    // Accepted starts
    logic        go_rr;
    logic        go_rx;
    logic [15:0] op_q;
    assign go_rr = start_i && !busy_o && op_hw_i[15:14] == 2'h0;
    assign go_rx = start_i && !busy_o && op_hw_i[15:14] == 2'h1;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_q <= 16'h0;
        end else if (start_i && !busy_o) begin
            op_q <= op_hw_i;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // ==========================================================
    // Fetch properties
    chk_rr_one_cycle: assert property (
        go_rr |=> busy_o ##1 (!busy_o && (exec_go_o || exception_override_o)))
        else $error("RR fetch length wrong");
    chk_rx_two_cycle: assert property (
        go_rx && op_hw_i[3:0] != 4'h0 |=> busy_o [*2] ##1 !busy_o)
        else $error("Indexed fetch length wrong");
    chk_rr_reset_act: assert property (
        go_rr |=> ##1 (sticky_clr_o && step_count_o == 3'h4 && aux_count_o == 3'h0))
        else $error("RR reset action wrong");
    chk_rx_reset_act: assert property (
        go_rx |=> ##[1:2] (sticky_clr_o && step_count_o == 3'h0 && aux_count_o == 3'h0))
        else $error("RX reset action wrong");
    chk_opcode_sel: assert property (
        go_rr |=> ##1 exec_branch_select_o == op_q[13:8])
        else $error("Dispatch select wrong");
    chk_exc_override: assert property (
        go_rr && exception_i |=> ##1 (exception_override_o && !exec_go_o))
        else $error("Exception did not override");
    chk_ic_advance: assert property (
        go_rr && !exec_i |=> ##1 instr_counter_o == $past(instr_counter_o) + 2'h1)
        else $error("Counter not advanced by one");
    chk_ic_frozen: assert property (
        (go_rr || go_rx) && exec_i |=> $stable(instr_counter_o) [*3])
        else $error("Counter moved under execute");
    chk_store_addr: assert property (
        go_rr |=> local_addr_latch_o == {op_q[13],
            (op_q[13:8] >= 6'h05 && op_q[13:8] <= 6'h07) ? op_q[7:4] : op_q[3:0]})
        else $error("Local store address wrong");
    chk_oper_addr: assert property (
        oper_req_o |-> oper_addr_o == fetch_ptr_o && !busy_o)
        else $error("Operand request address wrong");
endmodule // rrxif_fetch_sva

bind rrxif_fetch rrxif_fetch_sva u_rrxif_fetch_sva (.core_clk_i, .rstn_i, .start_i, .op_hw_i,
    .exec_i, .exception_i, .busy_o, .exec_branch_select_o, .exec_go_o, .exception_override_o,
    .sticky_clr_o, .instr_counter_o, .step_count_o, .aux_count_o, .local_addr_latch_o,
    .oper_req_o, .oper_addr_o, .fetch_ptr_o);

// ### testbench/rrxif_lstore_model.sv
`timescale 1ns/1ps
module rrxif_lstore_model (
    input  wire logic        core_clk_i,
    input  wire logic        rd_en_i,
    input  wire logic [4:0]  addr_i,
    input  wire logic        oper_req_i,
    output logic [31:0]      data_o
);
    logic [31:0] last_r = 32'h0;
    logic [1:0]  cyc_r = 2'h0;
    // Same-cycle read; upper half is the float bank
    // Idle bus shows the inverse so stale data cannot pass
    assign data_o = rd_en_i ? {16'h5A00, 11'h0, addr_i} : ~last_r;
    always @(posedge core_clk_i) begin
        if (rd_en_i) begin
            last_r <= data_o;
        end
        // Operand request holds storage three cycles
        if (oper_req_i) begin
            cyc_r <= 2'h3;
        end else if (cyc_r != 2'h0) begin
            cyc_r <= cyc_r - 2'h1;
        end
    end
endmodule // rrxif_lstore_model

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic        exc;
        logic        oreq;
        logic        ireq;
        logic [5:0]  sel;
        logic [1:0]  ic;
        logic [2:0]  step_count;
        logic [15:0] qhw;
        logic [31:0] fptr;
        logic [31:0] mir;
        logic [31:0] iaddr;
        logic [31:0] wa;
        logic [31:0] wb;
        logic [11:0] cwp;
    } rrxif_exp_s;
    logic core_clk_i, rstn_i, start_i, exec_i, exception_i, hsel_i, hwrite_i;
    logic busy_o, exec_go_o, exception_override_o, sticky_clr_o, stop_o, oper_req_o;
    logic instr_req_o, hreadyout_o, hresp_o;
    logic [1:0] htrans_i, instr_counter_o;
    logic [2:0] hsize_i, step_count_o, aux_count_o;
    logic [4:0] local_addr_latch_o;
    logic [5:0] exec_branch_select_o;
    logic [11:0] control_word_pointer_o;
    logic [15:0] op_hw_i, second_hw_i, next_hw_i, queued_hw_o, q_e;
    logic [31:0] hold_i, haddr_i, hwdata_i, hrdata_o, local_store_i, work_a_o, work_b_o;
    logic [31:0] fetch_ptr_o, mirror_o, hold_o, oper_addr_o, instr_addr_o, rd, lf;
    logic [1:0] ic_e;
    logic bc_fail_i, refill_need_i, refill_exc_i;
    logic [31:0] instr_counter_i, wa_e, wb_e;
    // Includes indexed branch-on-condition and store-halfword codes
    logic [15:0] ops [12] = '{16'h1A35, 16'h2835, 16'h0535, 16'h5A30, 16'h1A35, 16'h5A34,
                              16'h4134, 16'h5A30, 16'h6A34, 16'h5A34, 16'h4734, 16'h4034};
    int num_errors = 0;
    int tests_run = 0;
    int seed = 13623;
    rrxif_exp_s fq [$];
    rrxif_exp_s m;

    rrxif_fetch u_rrxif_fetch (.core_clk_i, .rstn_i, .start_i, .op_hw_i, .second_hw_i,
        .hold_i, .next_hw_i, .exec_i, .exception_i, .refill_exc_i, .bc_fail_i,
        .refill_need_i, .instr_counter_i, .busy_o, .control_word_pointer_o,
        .exec_branch_select_o, .exec_go_o, .exception_override_o, .sticky_clr_o,
        .instr_counter_o, .step_count_o, .aux_count_o, .stop_o, .queued_hw_o, .work_a_o,
        .work_b_o, .fetch_ptr_o, .mirror_o, .hold_o, .local_addr_latch_o, .local_store_i,
        .oper_req_o, .oper_addr_o, .instr_req_o, .instr_addr_o, .hsel_i, .haddr_i, .htrans_i,
        .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o,
        .hrdata_o);
    rrxif_lstore_model u_rrxif_lstore_model (.core_clk_i, .rd_en_i(busy_o),
        .addr_i(local_addr_latch_o), .oper_req_i(oper_req_o), .data_o(local_store_i));

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    // ==========================================================
    // Shared tasks
    function automatic logic [31:0] ls(input logic [4:0] a);
        return {16'h5A00, 11'h0, a};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    task automatic fetch(input logic [15:0] op, input logic [15:0] hw2, input logic xp,
                         input logic xc);
        rrxif_exp_s e;
        logic [31:0] h;
        logic [31:0] b;
        logic [15:0] nh;
        logic rx;
        logic br;
        logic idx;
        logic bf;
        logic rn;
        logic rf;
        logic [31:0] ia;
        h = $random(seed);
        ia = $random(seed);
        bf = 1'($random(seed));
        rn = 1'($random(seed));
        rf = 1'($random(seed));
        nh = 16'($random(seed));
        rx = op[14];
        idx = rx && op[3:0] != 4'h0;
        br = !rx && op[13:8] inside {[6'h05:6'h07]};
        b = ((hw2[15:12] == 4'h0) ? 32'h0 : h) + {20'h0, hw2[11:0]};
        e.exc = xc;
        e.sel = op[13:8];
        e.step_count = rx ? 3'h0 : 3'h4;
        e.fptr = !rx ? h : (idx ? ls({1'b0, op[3:0]}) + b : b);
        e.mir = ls({op[13], (rx || br) ? op[7:4] : op[3:0]});
        e.oreq = rx && !rf && !(op[13:8] inside {6'h00, 6'h01, 6'h02, 6'h07});
        e.ireq = (rx ? op[13:8] == 6'h07 : br) && (!bf || (!xp && rn));
        e.iaddr = bf ? ia : (rx ? e.fptr : h);
        e.cwp = {6'h08, op[15:14], rx && op[3:0] == 4'h0, rx && hw2[15:12] == 4'h0, ic_e};
        if (!rx) {wa_e, wb_e} = {h, h};
        else if (idx) wb_e = b;
        e.wa = wa_e;
        e.wb = wb_e;
        if (!xp && !(rx && ic_e == 2'h2)) q_e = nh;
        if (!xp) ic_e = ic_e + (rx ? 2'h2 : 2'h1);
        e.ic = ic_e;
        e.qhw = q_e;
        lf = e.fptr;
        fq.push_back(e);
        @(posedge core_clk_i);
        start_i <= 1'b1;
        op_hw_i <= op;
        second_hw_i <= hw2;
        hold_i <= h;
        next_hw_i <= nh;
        exec_i <= xp;
        exception_i <= xc;
        bc_fail_i <= bf;
        refill_need_i <= rn;
        refill_exc_i <= rf;
        instr_counter_i <= ia;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        repeat (idx ? 2 : 1) @(posedge core_clk_i);
    endtask
    // ==========================================================
    // Result monitor
    always @(posedge core_clk_i) begin
        if (exec_go_o === 1'b1 || exception_override_o === 1'b1) begin
            if (fq.size() == 0) begin
                cmp(32'h1, 32'h0, "unexpected result");
            end else begin
                m = fq.pop_front();
                cmp(exception_override_o, m.exc, "exception");
                if (!m.exc) begin
                    cmp(exec_branch_select_o, m.sel, "select");
                    cmp(fetch_ptr_o, m.fptr, "fetch ptr");
                    cmp(mirror_o, m.mir, "mirror");
                    cmp(instr_counter_o, m.ic, "counter");
                    cmp(step_count_o, m.step_count, "step count");
                    cmp(queued_hw_o, m.qhw, "queued hw");
                    cmp(oper_req_o, m.oreq, "oper req");
                    cmp(instr_req_o, m.ireq, "instr req");
                    cmp(hold_o, m.mir, "hold");
                    cmp(work_a_o, m.wa, "work a");
                    cmp(work_b_o, m.wb, "work b");
                    cmp(control_word_pointer_o, m.cwp, "cw pointer");
                    if (m.ireq) cmp(instr_addr_o, m.iaddr, "instr addr");
                end
            end
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        {rstn_i, start_i, exec_i, exception_i, hsel_i, hwrite_i} = 6'h0;
        {htrans_i, op_hw_i, second_hw_i, next_hw_i, hold_i, haddr_i, hwdata_i} = 0;
        {bc_fail_i, refill_need_i, refill_exc_i, instr_counter_i, wa_e, wb_e} = 0;
        hsize_i = 3'h2;
        ic_e = 2'h0;
        q_e = 16'h0;
        repeat (6) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rd = $random(seed);
            if (i[0]) rd[15:12] = 4'h0;
            fetch(ops[i], rd[15:0], 1'b0, 1'b0);
        end
        fetch(16'h1A35, 16'h0, 1'b1, 1'b0);
        fetch(16'h5A34, 16'h7123, 1'b1, 1'b0);
        ahb(1'b1, 32'h0, 32'h1);
        ahb(1'b0, 32'h0, 32'h0);
        cmp(rd, 32'h1, "ctrl readback");
        fetch(16'h1A35, 16'h0, 1'b0, 1'b0);
        ahb(1'b0, 32'h4, 32'h0);
        cmp(rd, {18'h0, 4'h1, 1'b0, 1'b1, 3'h0, 3'h4, ic_e}, "status stop");
        ahb(1'b0, 32'h8, 32'h0);
        cmp(rd, lf, "fetch ptr reg");
        ahb(1'b1, 32'h0, 32'h2);
        ahb(1'b0, 32'hC, 32'h0);
        cmp(rd, 32'h0, "unmapped");
        cmp(stop_o, 1'b0, "stop cleared");
        fetch(16'h1A35, 16'h0, 1'b0, 1'b1);
        repeat (4) @(posedge core_clk_i);
        cmp(fq.size(), 0, "results missing");
        finish_test();
    end
    initial begin
        #200000;
        num_errors++;
        $display("FAIL %0t watchdog expired", $time);
        finish_test();
    end
endmodule // testbench
